//--- shared/pmmd_pkg.sv
package pmmd_pkg;

  // Address space
  localparam int          PMMD_PC_W        = 21;
  localparam logic [20:0] PMMD_RESET_VEC   = 21'h000000;
  localparam logic [20:0] PMMD_HI_VEC      = 21'h000008;
  localparam logic [20:0] PMMD_LO_VEC      = 21'h000018;
  localparam logic [20:0] PMMD_KB          = 21'h000400;
  localparam logic [20:0] PMMD_CFG_SPAN    = 21'h000008;
  localparam logic [20:0] PMMD_CFG_BYTE3L  = 21'h000004;
  localparam int          PMMD_CFG_BYTES   = 8;

  // Bus config byte fields
  localparam int          PMMD_WAIT_BIT    = 7;
  localparam int          PMMD_BW_BIT      = 6;
  localparam int          PMMD_MODE_HI     = 5;
  localparam int          PMMD_MODE_LO     = 4;
  localparam int          PMMD_SHIFT_BIT   = 3;
  localparam logic [7:0]  PMMD_CFG_RESET   = 8'hF8;
  localparam logic [7:0]  PMMD_CFG_MASK    = 8'hF8;

  // Mode field encodings
  localparam logic [1:0]  PMMD_MODE_INT    = 2'h3;
  localparam logic [1:0]  PMMD_MODE_A12    = 2'h2;
  localparam logic [1:0]  PMMD_MODE_A16    = 2'h1;
  localparam logic [1:0]  PMMD_MODE_A20    = 2'h0;

  // Address width codes on output
  localparam logic [1:0]  PMMD_AW_12       = 2'h0;
  localparam logic [1:0]  PMMD_AW_16       = 2'h1;
  localparam logic [1:0]  PMMD_AW_20       = 2'h2;

  // Pending answer source for a taken fetch
  localparam logic [1:0]  PMMD_PEND_NONE   = 2'h0;
  localparam logic [1:0]  PMMD_PEND_FLASH  = 2'h1;
  localparam logic [1:0]  PMMD_PEND_EXT    = 2'h2;
  localparam logic [1:0]  PMMD_PEND_ZERO   = 2'h3;

  // Register port
  localparam logic [3:0]  PMMD_REG_CFG     = 4'h0;
  localparam logic [3:0]  PMMD_REG_STATUS  = 4'h1;
  localparam logic [3:0]  PMMD_REG_VEC     = 4'h2;

  // Fetch target regions
  typedef enum logic [1:0] {
    PMMD_TGT_FLASH,
    PMMD_TGT_CFG,
    PMMD_TGT_EXT,
    PMMD_TGT_ZERO
  } pmmd_tgt_t;

  typedef enum logic [1:0] {
    PMMD_ST_LOAD,
    PMMD_ST_WAIT,
    PMMD_ST_RUN
  } pmmd_state_t;

endpackage : pmmd_pkg

//--- hw/pmmd_ext_addr.sv
`timescale 1ns/1ps
// External address forming: shift and width masking
module pmmd_ext_addr
  import pmmd_pkg::*;
#(
  parameter logic [20:0] TOP = 21'h010000
)
(
  // Request
  input  wire logic [20:0] i_addr,
  input  wire logic        i_shift,
  input  wire logic [1:0]  i_mode,
  // Result
  output logic [19:0]      o_ext_addr
);

  logic [20:0] shifted;
  logic [20:0] masked;

  always_comb
  begin
    shifted = i_shift ? (i_addr - TOP) : i_addr;            // [RQ11] [RQ16]
    masked  = shifted;
    if (i_mode == PMMD_MODE_A12)
    begin
      masked = shifted & 21'h000FFF;                        // [RQ10]
    end
    else if (i_mode == PMMD_MODE_A16)
    begin
      masked = shifted & 21'h00FFFF;                        // [RQ10]
    end
    o_ext_addr = masked[19:0];
  end

endmodule : pmmd_ext_addr

//--- hw/pmmd_decoder.sv
`timescale 1ns/1ps
// Behaviour
// (RQ1) Program counter is 21 bits, 2 MB
// (RQ2) Unmapped space above flash reads zero
// (RQ3) Every reset loads program counter zero
// (RQ4) Interrupt vectors at 0008h and 0018h
// (RQ5) Top four flash words hold configuration
// (RQ6) Config bytes ascending; fourth word reserved
// (RQ7) Config region is last eight flash bytes
// (RQ8) Internal-only mode: flash only, bus off
// (RQ9) Extended mode: above flash goes external
// (RQ10) Mode field bits 5:4 selects width
// (RQ11) Shift bit remaps external base to zero
// (RQ12) Wait bit one disables wait states
// (RQ13) Bus width bit selects 16-bit data
// (RQ14) No-bus variant: internal-only, bits absent
// (RQ15) Data RAM untouched, separate bus
// (RQ16) Shifted address is PC minus flash size
// (RQ17) Flash size is a parameter
module pmmd_decoder
  import pmmd_pkg::*;
#(
  parameter int FLASH_KB = 64,                              // [RQ17]
  parameter bit HAS_BUS  = 1'b1
)
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Core fetch side
  input  wire logic        i_fetch,
  input  wire logic [20:0] i_addr,
  input  wire logic        i_vec_hi,
  input  wire logic        i_vec_lo,
  output logic [20:0]      o_pc,
  output logic [15:0]      o_fetch_data,
  output logic             o_fetch_valid,
  output logic             o_cfg_ready,
  // On-chip flash
  output logic             o_flash_rd,
  output logic [20:0]      o_flash_addr,
  input  wire logic [15:0] i_flash_data,
  // External memory bus
  output logic             o_ext_rd,
  output logic [19:0]      o_ext_addr,
  output logic             o_ext_en,
  output logic [1:0]       o_ext_aw,
  output logic             o_ext_bw16,
  output logic             o_ext_wait_en,
  input  wire logic [15:0] i_ext_data,
  // Register port
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [7:0]       o_reg_rdata
);

  // Top of on-chip flash; everything above is external or zero
  localparam logic [20:0] TOP =
    21'(FLASH_KB) * PMMD_KB;                                // [RQ17]
  localparam logic [20:0] CFG_BASE = TOP - PMMD_CFG_SPAN;   // [RQ7]

  function automatic pmmd_tgt_t region(input logic [20:0] a,
                                       input logic        ext);
    if (a >= CFG_BASE && a < TOP)
    begin
      return PMMD_TGT_CFG;                                  // [RQ7]
    end
    else if (a < TOP)
    begin
      return PMMD_TGT_FLASH;
    end
    else if (ext)
    begin
      return PMMD_TGT_EXT;                                  // [RQ9]
    end
    return PMMD_TGT_ZERO;                                   // [RQ2] [RQ8]
  endfunction : region

  // Targets that the on-chip flash answers, config words included
  function automatic logic flash_hit(input pmmd_tgt_t t);
    return (t == PMMD_TGT_FLASH) || (t == PMMD_TGT_CFG);    // [RQ7]
  endfunction : flash_hit

  // Source of the answer two cycles after a taken fetch
  function automatic logic [1:0] pend_code(input pmmd_tgt_t t);
    if (t == PMMD_TGT_EXT)
    begin
      return PMMD_PEND_EXT;                                 // [RQ9]
    end
    else if (t == PMMD_TGT_ZERO)
    begin
      return PMMD_PEND_ZERO;                                // [RQ2]
    end
    return PMMD_PEND_FLASH;
  endfunction : pend_code

  // Width code for the external address bus
  function automatic logic [1:0] aw_code(input logic [1:0] m);
    if (m == PMMD_MODE_A12)
    begin
      return PMMD_AW_12;                                    // [RQ10]
    end
    else if (m == PMMD_MODE_A16)
    begin
      return PMMD_AW_16;                                    // [RQ10]
    end
    return PMMD_AW_20;                                      // [RQ10]
  endfunction : aw_code

  pmmd_state_t state_q;
  logic [7:0]  cfg_q;
  logic        cfg_written_q;
  logic [20:0] pc_q;
  logic [20:0] flash_addr_q;
  logic        flash_rd_q;
  logic        ext_rd_q;
  logic [19:0] ext_addr_q;
  logic [15:0] fetch_data_q;
  logic        fetch_valid_q;
  logic [1:0]  pend_q;
  logic [7:0]  rdata_q;
  logic [1:0]  ext_aw_q;
  logic        ext_en_q;
  logic        bw_q;
  logic        wait_q;
  logic        ready_q;

  logic [1:0]  mode;
  logic        ext_mode;
  logic [19:0] ext_addr_d;
  pmmd_tgt_t   tgt;

  // No-bus variant forces internal-only and hides the bits
  assign mode     = HAS_BUS ? cfg_q[PMMD_MODE_HI:PMMD_MODE_LO]
                            : PMMD_MODE_INT;                // [RQ14]
  assign ext_mode = (mode != PMMD_MODE_INT);                // [RQ8] [RQ10]
  assign tgt      = region(i_addr, ext_mode);

  pmmd_ext_addr #(
    .TOP (TOP)
  ) u_ext_addr (
    .i_addr     (i_addr),
    .i_shift    (cfg_q[PMMD_SHIFT_BIT]),
    .i_mode     (mode),
    .o_ext_addr (ext_addr_d)
  );

  // Config load: read word holding the bus config byte, then run
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= PMMD_ST_LOAD;                              // [RQ5]
      ready_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        PMMD_ST_LOAD: state_q <= PMMD_ST_WAIT;
        PMMD_ST_WAIT: state_q <= PMMD_ST_RUN;
        default:      state_q <= PMMD_ST_RUN;
      endcase
      // Own flop so the ready output is not decoded from state bits
      ready_q <= (state_q != PMMD_ST_LOAD);                 // [RQ5]
    end
  end

  // Bus config byte: loaded from flash, then write-once by software
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cfg_q         <= PMMD_CFG_RESET;
      cfg_written_q <= 1'b0;
    end
    else if (state_q == PMMD_ST_WAIT)
    begin
      // Byte 4 of region is the low byte of word three
      cfg_q <= i_flash_data[7:0] & PMMD_CFG_MASK;           // [RQ5] [RQ6]
    end
    else if (state_q == PMMD_ST_RUN && i_reg_wr &&
             i_reg_addr == PMMD_REG_CFG && !cfg_written_q)
    begin
      cfg_q         <= i_reg_wdata & PMMD_CFG_MASK;
      cfg_written_q <= 1'b1;
    end
  end

  // Program counter: reset vector, then vectors or fetch address
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      pc_q <= PMMD_RESET_VEC;                               // [RQ3]
    end
    else if (i_vec_hi)
    begin
      pc_q <= PMMD_HI_VEC;                                  // [RQ4]
    end
    else if (i_vec_lo)
    begin
      pc_q <= PMMD_LO_VEC;                                  // [RQ4]
    end
    else if (i_fetch && state_q == PMMD_ST_RUN)
    begin
      pc_q <= i_addr;                                       // [RQ1]
    end
  end

  // Fetch dispatch, one cycle to the memories
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      flash_rd_q   <= 1'b0;
      flash_addr_q <= PMMD_RESET_VEC;
      ext_rd_q     <= 1'b0;
      ext_addr_q   <= 20'h00000;
      pend_q       <= PMMD_PEND_NONE;
    end
    else if (state_q == PMMD_ST_LOAD)
    begin
      flash_rd_q   <= 1'b1;
      flash_addr_q <= CFG_BASE + PMMD_CFG_BYTE3L;           // [RQ6]
      ext_rd_q     <= 1'b0;
      pend_q       <= PMMD_PEND_NONE;
    end
    // A fetch before the config load ends is dropped, not queued
    else if (state_q == PMMD_ST_RUN && i_fetch)
    begin
      flash_rd_q   <= flash_hit(tgt);                       // [RQ7]
      flash_addr_q <= i_addr;
      ext_rd_q     <= (tgt == PMMD_TGT_EXT);                // [RQ9]
      ext_addr_q   <= ext_addr_d;                           // [RQ11]
      pend_q       <= pend_code(tgt);                       // [RQ2]
    end
    else
    begin
      flash_rd_q <= 1'b0;
      ext_rd_q   <= 1'b0;
      pend_q     <= PMMD_PEND_NONE;
    end
  end

  // Return data, one cycle after the memory read
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      fetch_data_q  <= 16'h0000;
      fetch_valid_q <= 1'b0;
    end
    else
    begin
      // Memories answer within the strobe cycle; taken at its end
      fetch_valid_q <= (pend_q != PMMD_PEND_NONE);
      if (pend_q == PMMD_PEND_FLASH)
      begin
        fetch_data_q <= i_flash_data;
      end
      else if (pend_q == PMMD_PEND_EXT)
      begin
        fetch_data_q <= i_ext_data;
      end
      else
      begin
        fetch_data_q <= 16'h0000;                           // [RQ2]
      end
    end
  end

  // Bus configuration outputs, registered from the config byte
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ext_en_q <= 1'b0;
      ext_aw_q <= PMMD_AW_20;
      bw_q     <= 1'b0;
      wait_q   <= 1'b0;
    end
    else
    begin
      ext_en_q <= ext_mode && state_q == PMMD_ST_RUN;       // [RQ8]
      ext_aw_q <= aw_code(mode);                            // [RQ10]
      bw_q     <= HAS_BUS && cfg_q[PMMD_BW_BIT];            // [RQ13]
      // Count itself lives in the memory bus control register
      wait_q   <= HAS_BUS && !cfg_q[PMMD_WAIT_BIT];         // [RQ12]
    end
  end

  // Register reads; data RAM never passes through here
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rdata_q <= 8'h00;
    end
    else if (i_reg_rd)
    begin
      if (i_reg_addr == PMMD_REG_CFG)
      begin
        rdata_q <= HAS_BUS ? cfg_q : 8'h00;                 // [RQ14]
      end
      else if (i_reg_addr == PMMD_REG_STATUS)
      begin
        rdata_q <= {5'h00, cfg_written_q, ext_mode,
                    state_q == PMMD_ST_RUN};
      end
      else if (i_reg_addr == PMMD_REG_VEC)
      begin
        rdata_q <= pc_q[7:0];
      end
      else
      begin
        rdata_q <= 8'h00;
      end
    end
    else
    begin
      rdata_q <= 8'h00;
    end
  end

  assign o_pc          = pc_q;
  assign o_fetch_data  = fetch_data_q;
  assign o_fetch_valid = fetch_valid_q;                     // [RQ15]
  assign o_cfg_ready   = ready_q;
  assign o_flash_rd    = flash_rd_q;
  assign o_flash_addr  = flash_addr_q;
  assign o_ext_rd      = ext_rd_q;
  assign o_ext_addr    = ext_addr_q;
  assign o_ext_en      = ext_en_q;
  assign o_ext_aw      = ext_aw_q;
  assign o_ext_bw16    = bw_q;
  assign o_ext_wait_en = wait_q;
  assign o_reg_rdata   = rdata_q;

endmodule : pmmd_decoder

//--- test/pmmd_props.sv
`timescale 1ns/1ps
module pmmd_props
  import pmmd_pkg::*;
#(
  parameter int FLASH_KB = 64
)
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  // Fetch side
  input wire logic        i_fetch,
  input wire logic [20:0] i_addr,
  input wire logic        i_vec_hi,
  input wire logic        i_vec_lo,
  input wire logic [20:0] o_pc,
  input wire logic [15:0] o_fetch_data,
  input wire logic        o_fetch_valid,
  input wire logic        o_cfg_ready,
  // Memories
  input wire logic        o_flash_rd,
  input wire logic [20:0] o_flash_addr,
  input wire logic        o_ext_rd,
  input wire logic        o_ext_en
);
  localparam logic [20:0] TOP = 21'(FLASH_KB) * PMMD_KB;
  localparam logic [20:0] CFG = TOP - PMMD_CFG_SPAN + PMMD_CFG_BYTE3L;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_take;
    i_fetch && o_cfg_ready;
  endsequence
  sequence s_low;
    s_take ##0 (i_addr < TOP);
  endsequence
  sequence s_high;
    s_take ##0 (i_addr >= TOP);
  endsequence
  AST_RST_PC: assert property (disable iff (1'b0)
    !i_rst_n |=> o_pc == PMMD_RESET_VEC) else $error("pc not cleared");
  AST_CFG_LOAD: assert property ($rose(i_rst_n) |=>
    o_flash_rd && o_flash_addr == CFG) else $error("no config load");
  AST_PC_TAKE: assert property (s_take |=>
    o_pc == $past(i_addr)) else $error("pc not fetch address");
  AST_VEC_HI: assert property (i_vec_hi && !i_fetch |=>
    o_pc == PMMD_HI_VEC) else $error("high vector wrong");
  AST_VEC_LO: assert property (i_vec_lo && !i_vec_hi && !i_fetch |=>
    o_pc == PMMD_LO_VEC) else $error("low vector wrong");
  AST_FLASH_RT: assert property (s_low |=> o_flash_rd &&
    !o_ext_rd && o_flash_addr == $past(i_addr)) else $error("flash route");
  AST_EXT_RT: assert property (s_high ##0 o_ext_en |=>
    o_ext_rd && !o_flash_rd) else $error("external route");
  AST_ZERO: assert property (s_high ##0 !o_ext_en |-> ##2
    o_fetch_valid && o_fetch_data == 16'h0000) else $error("not zero");
  AST_NO_BUS: assert property (!o_ext_en |-> !o_ext_rd)
    else $error("bus used while off");
endmodule : pmmd_props
bind pmmd_decoder pmmd_props #(.FLASH_KB(FLASH_KB)) u_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_fetch(i_fetch), .i_addr(i_addr),
  .i_vec_hi(i_vec_hi), .i_vec_lo(i_vec_lo), .o_pc(o_pc),
  .o_fetch_data(o_fetch_data), .o_fetch_valid(o_fetch_valid),
  .o_cfg_ready(o_cfg_ready), .o_flash_rd(o_flash_rd),
  .o_flash_addr(o_flash_addr), .o_ext_rd(o_ext_rd), .o_ext_en(o_ext_en));

//--- test/pmmd_mem_model.sv
`timescale 1ns/1ps
module pmmd_mem_model
#(
  parameter logic [20:0] CFG_ADDR = 21'h00FFFC
)
(
  input  wire logic        i_clk,
  input  wire logic        i_flash_rd,
  input  wire logic [20:0] i_flash_addr,
  input  wire logic        i_ext_rd,
  input  wire logic [19:0] i_ext_addr,
  input  wire logic [7:0]  i_cfg,
  output logic [15:0]      o_flash_data,
  output logic [15:0]      o_ext_data
);
  logic [15:0] idle_q = 16'hC3C3;
  // Answer within the strobe cycle, as the decoder takes data at its end;
  // idle cycles toggle so stale reads cannot pass
  always_ff @(posedge i_clk)
    idle_q <= ~idle_q;
  assign o_flash_data = !i_flash_rd ? idle_q :
    (i_flash_addr == CFG_ADDR) ? {8'h00, i_cfg} :
    i_flash_addr[16:1] ^ 16'h1234;
  assign o_ext_data = i_ext_rd ? i_ext_addr[15:0] ^ 16'h5A5A : ~idle_q;
endmodule : pmmd_mem_model

//--- test/test_program_memory_map_decoder.sv
`timescale 1ns/1ps
module test_program_memory_map_decoder;
  import pmmd_pkg::*;
  localparam logic [20:0] TOP = 21'h010000;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_fetch = 1'b0;
  logic i_vec_hi = 1'b0, i_vec_lo = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [20:0] i_addr = 21'h000000;
  logic [3:0] i_reg_addr = 4'h0;
  logic [7:0] i_reg_wdata = 8'h00, cfg = 8'hF8, c, d;
  logic [15:0] fd, xd, o_fetch_data;
  logic [20:0] o_pc, o_flash_addr;
  logic [19:0] o_ext_addr, ea;
  logic [1:0] o_ext_aw, m;
  logic [7:0] o_reg_rdata;
  logic o_fetch_valid, o_cfg_ready, o_flash_rd, o_ext_rd, o_ext_en, ex;
  logic o_ext_bw16, o_ext_wait_en;
  logic [7:0] cfgs [4] = '{8'hF8, 8'hA0, 8'h5F, 8'h00};
  int miscompares = 0, cmp_count = 0;
  always #4 i_clk = ~i_clk;
  pmmd_decoder #(.FLASH_KB(64), .HAS_BUS(1'b1)) uut (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_fetch(i_fetch), .i_addr(i_addr),
    .i_vec_hi(i_vec_hi), .i_vec_lo(i_vec_lo), .o_pc(o_pc),
    .o_fetch_data(o_fetch_data), .o_fetch_valid(o_fetch_valid),
    .o_cfg_ready(o_cfg_ready), .o_flash_rd(o_flash_rd),
    .o_flash_addr(o_flash_addr), .i_flash_data(fd), .o_ext_rd(o_ext_rd),
    .o_ext_addr(o_ext_addr), .o_ext_en(o_ext_en), .o_ext_aw(o_ext_aw),
    .o_ext_bw16(o_ext_bw16), .o_ext_wait_en(o_ext_wait_en),
    .i_ext_data(xd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
  pmmd_mem_model u_mem (.i_clk(i_clk), .i_flash_rd(o_flash_rd),
    .i_flash_addr(o_flash_addr), .i_ext_rd(o_ext_rd),
    .i_ext_addr(o_ext_addr), .i_cfg(cfg), .o_flash_data(fd),
    .o_ext_data(xd));
  task automatic check(string n, logic [20:0] e, logic [20:0] s);
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task final_report;
    $display("Comparisons %0d, errors %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic do_reset(input logic [7:0] v);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    cfg <= v;
    repeat (20) @(posedge i_clk);
    check("pc_reset", PMMD_RESET_VEC, o_pc);
    i_rst_n <= 1'b1;
    // Ready one cycle after the config load strobe
    repeat (4) @(posedge i_clk);
    #1 check("cfg_ready", 1, o_cfg_ready);
  endtask : do_reset
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] r);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 r = o_reg_rdata;
  endtask : rd_reg
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wdata <= v;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask : wr_reg
  task automatic fetch(input logic [20:0] a, input logic [15:0] e,
                       input logic x, input logic [19:0] xa);
    @(posedge i_clk);
    i_fetch <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_fetch <= 1'b0;
    #1 check("flash_rd", a < TOP, o_flash_rd);
    check("ext_rd", x, o_ext_rd);
    if (x)
      check("ext_addr", xa, o_ext_addr);
    check("pc", a, o_pc);
    @(posedge i_clk);
    #1 check("valid", 1, o_fetch_valid);
    check("data", e, o_fetch_data);
  endtask : fetch
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      c = cfgs[i];
      m = c[5:4];
      ex = (m != PMMD_MODE_INT);
      do_reset(c);
      rd_reg(PMMD_REG_CFG, d);
      check("cfg_byte", c & 8'hF8, d);
      check("ext_en", ex, o_ext_en);
      rd_reg(PMMD_REG_STATUS, d);
      check("status", {6'h00, ex, 1'b1}, d);
      if (ex)
      begin
        check("aw", (m == PMMD_MODE_A12) ? PMMD_AW_12 :
              (m == PMMD_MODE_A16) ? PMMD_AW_16 : PMMD_AW_20, o_ext_aw);
        check("bw16", c[6], o_ext_bw16);
        check("wait_en", !c[7], o_ext_wait_en);
      end
      fetch(21'h000100, 16'h0080 ^ 16'h1234, 1'b0, 20'h0);
      fetch(21'h00FFFE, 16'h7FFF ^ 16'h1234, 1'b0, 20'h0);
      ea = c[3] ? 20'h02346 : 20'h12346;
      ea = (m == PMMD_MODE_A12) ? (ea & 20'h00FFF) :
           (m == PMMD_MODE_A16) ? (ea & 20'h0FFFF) : ea;
      fetch(TOP + 21'h002346, ex ? ea[15:0] ^ 16'h5A5A : 16'h0000, ex,
            ea);
    end
    @(posedge i_clk);
    i_vec_hi <= 1'b1;
    i_vec_lo <= 1'b1;
    @(posedge i_clk);
    i_vec_hi <= 1'b0;
    i_vec_lo <= 1'b0;
    #1 check("vec_hi", PMMD_HI_VEC, o_pc);
    @(posedge i_clk);
    i_vec_lo <= 1'b1;
    @(posedge i_clk);
    i_vec_lo <= 1'b0;
    #1 check("vec_lo", PMMD_LO_VEC, o_pc);
    rd_reg(PMMD_REG_VEC, d);
    check("pc_low", 8'h18, d);
    wr_reg(4'hF, 8'hFF);
    rd_reg(4'hF, d);
    check("unmapped", 8'h00, d);
    rd_reg(PMMD_REG_CFG, d);
    check("cfg_kept", 8'h00, d);
    wr_reg(PMMD_REG_CFG, 8'hA8);
    wr_reg(PMMD_REG_CFG, 8'h57);
    rd_reg(PMMD_REG_CFG, d);
    check("cfg_once", 8'hA8, d);
    check("aw_sw", PMMD_AW_12, o_ext_aw);
    check("ext_en_sw", 1, o_ext_en);
    final_report();
  end
  initial
  begin
    #100000;
    miscompares++;
    final_report();
  end
endmodule : test_program_memory_map_decoder
